// ---- aoms_pkg.sv ----
/*
 * Constants shared by the trim and magnetic status register bank.
 * Assumes a host serial engine that turns frames into register strobes.
 */
// Overview of operation
// - Each axis trim register holds a signed byte worth 2 mg per step.
// - The trim therefore spans -256 mg to +254 mg on every axis.
// - Trim is added to each raw sample before it lands at 0x01 to 0x06.
// - Trim may change only in standby, and the host must enter it first.
// - X, Y and Z trims sit at 0x2f, 0x30 and 0x31 and reset to zero.
// - Status at 0x32 is read-only: overwrite flags 7..4, new data 3..0.
// - All-axes overwrite sets when any axis gets new data over its unread data.
// - All-axes overwrite clears once the X, Y and Z high bytes are read.
// - Z overwrite sets on Z data over unread Z, clears on Z high read.
// - Y overwrite sets on Y data over unread Y, clears on Y high read.
// - X overwrite sets on X data over unread X, clears on X high read.
// - All-axes new data sets on a full set, clears once X, Y and Z high bytes are read.
// - Each axis new-data flag sets on its sample, clears on its read.
package aoms_pkg;
   localparam logic [7:0] ADDR_ACC_X_HI = 8'h01;
   localparam logic [7:0] ADDR_ACC_X_LO = 8'h02;
   localparam logic [7:0] ADDR_ACC_Y_HI = 8'h03;
   localparam logic [7:0] ADDR_ACC_Y_LO = 8'h04;
   localparam logic [7:0] ADDR_ACC_Z_HI = 8'h05;
   localparam logic [7:0] ADDR_ACC_Z_LO = 8'h06;
   localparam logic [7:0] ADDR_X_TRIM   = 8'h2f;
   localparam logic [7:0] ADDR_Y_TRIM   = 8'h30;
   localparam logic [7:0] ADDR_Z_TRIM   = 8'h31;
   localparam logic [7:0] ADDR_MAG_STAT = 8'h32;
   localparam logic [7:0] ADDR_MAG_X_HI = 8'h33;
   localparam logic [7:0] ADDR_MAG_Y_HI = 8'h35;
   localparam logic [7:0] ADDR_MAG_Z_HI = 8'h37;
   localparam logic [7:0] TRIM_RESET    = 8'h00;
   localparam logic [7:0] STAT_RESET    = 8'h00;
   localparam int         TRIM_MG_LSB   = 2;    // Trim step in mg
   localparam int         STAT_ALL_OW   = 7;
   localparam int         STAT_OW_LO    = 4;
   localparam int         STAT_ALL_DR   = 3;
   localparam int         STAT_DR_LO    = 0;
endpackage

// ---- aoms_regs.sv ----
/*
 * Accelerometer trim, corrected output data and magnetic status bank.
 * Assumes one-cycle register strobes from the serial engine, a standby
 * level from mode control, and one-cycle sample strobes from the core.
 */
`timescale 1ns/1ps
module aoms_regs #(
   parameter int SAMPLE_W   = 14,
   parameter int TRIM_SHIFT = 3
) (
   input  wire logic                i_clk_sys,
   input  wire logic                i_reset_n,
   input  wire logic                i_standby,
   input  wire logic [7:0]          i_reg_addr,
   input  wire logic                i_reg_wr,
   input  wire logic [7:0]          i_reg_wdata,
   input  wire logic                i_reg_rd,
   output logic      [7:0]          o_reg_rdata,
   input  wire logic                i_accel_valid,
   input  wire logic [SAMPLE_W-1:0] i_accel_x,
   input  wire logic [SAMPLE_W-1:0] i_accel_y,
   input  wire logic [SAMPLE_W-1:0] i_accel_z,
   input  wire logic [2:0]          i_mag_done,
   output logic      [7:0]          o_mag_status
);
   logic [7:0]          accel_x_trim;
   logic [7:0]          accel_y_trim;
   logic [7:0]          accel_z_trim;
   logic [SAMPLE_W-1:0] acc_x;
   logic [SAMPLE_W-1:0] acc_y;
   logic [SAMPLE_W-1:0] acc_z;
   logic [2:0]          axis_dr;
   logic [2:0]          axis_ow;
   logic                all_dr;
   logic                all_ow;
   logic [2:0]          hi_seen;
   logic [2:0]          hi_rd;
   logic [2:0]          next_axis_dr;
   logic [2:0]          next_seen;
   logic                wr_ok;

   // Width of the trim sum, wide enough that the add can never wrap
   localparam int SUM_W = SAMPLE_W + TRIM_SHIFT + 9;

   // Saturating add of a scaled signed trim onto a signed sample
   function automatic logic [SAMPLE_W-1:0] add_trim(
      input logic [SAMPLE_W-1:0] raw,
      input logic [7:0]          trim
   );
      logic signed [SUM_W-1:0] sum;
      logic signed [SUM_W-1:0] lim_hi;
      logic signed [SUM_W-1:0] lim_lo;
      sum = ($signed({{(TRIM_SHIFT+9){raw[SAMPLE_W-1]}}, raw}))
          + ($signed({{(SAMPLE_W+TRIM_SHIFT+1){trim[7]}}, trim})
             <<< TRIM_SHIFT);
      lim_hi = SUM_W'((1 <<< (SAMPLE_W-1)) - 1);
      lim_lo = SUM_W'(-(1 <<< (SAMPLE_W-1)));
      if (sum > lim_hi) begin
         add_trim = {1'b0, {(SAMPLE_W-1){1'b1}}};
      end else if (sum < lim_lo) begin
         add_trim = {1'b1, {(SAMPLE_W-1){1'b0}}};
      end else begin
         add_trim = sum[SAMPLE_W-1:0];
      end
   endfunction

   // High byte of a left-justified sample
   function automatic logic [7:0] hi_byte(input logic [SAMPLE_W-1:0] s);
      logic [15:0] j;
      j = {s, {(16-SAMPLE_W){1'b0}}};
      hi_byte = j[15:8];
   endfunction

   // Low byte of a left-justified sample
   function automatic logic [7:0] lo_byte(input logic [SAMPLE_W-1:0] s);
      logic [15:0] j;
      j = {s, {(16-SAMPLE_W){1'b0}}};
      lo_byte = j[7:0];
   endfunction

   // Active-mode writes are dropped so a running conversion never sees
   // a trim change part way through a sample set
   assign wr_ok = i_reg_wr && i_standby;

   // Trim registers, signed byte at 2 mg per step
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         accel_x_trim <= aoms_pkg::TRIM_RESET;
         accel_y_trim <= aoms_pkg::TRIM_RESET;
         accel_z_trim <= aoms_pkg::TRIM_RESET;
      end else if (wr_ok) begin
         if (i_reg_addr == aoms_pkg::ADDR_X_TRIM) begin
            accel_x_trim <= i_reg_wdata;
         end
         if (i_reg_addr == aoms_pkg::ADDR_Y_TRIM) begin
            accel_y_trim <= i_reg_wdata;
         end
         if (i_reg_addr == aoms_pkg::ADDR_Z_TRIM) begin
            accel_z_trim <= i_reg_wdata;
         end
      end
   end

   // Corrected acceleration output data
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         acc_x <= '0;
         acc_y <= '0;
         acc_z <= '0;
      end else if (i_accel_valid) begin
         acc_x <= add_trim(i_accel_x, accel_x_trim);
         acc_y <= add_trim(i_accel_y, accel_y_trim);
         acc_z <= add_trim(i_accel_z, accel_z_trim);
      end
   end

   // Reads of the magnetic high bytes, bit order X, Y, Z
   assign hi_rd[0] = i_reg_rd && (i_reg_addr == aoms_pkg::ADDR_MAG_X_HI);
   assign hi_rd[1] = i_reg_rd && (i_reg_addr == aoms_pkg::ADDR_MAG_Y_HI);
   assign hi_rd[2] = i_reg_rd && (i_reg_addr == aoms_pkg::ADDR_MAG_Z_HI);

   // New sample beats a same-cycle read so no event is lost
   assign next_axis_dr = i_mag_done | (axis_dr & ~hi_rd);

   // Per-axis new-data and overwrite flags
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         axis_dr <= '0;
         axis_ow <= '0;
      end else begin
         axis_dr <= next_axis_dr;
         axis_ow <= (i_mag_done & axis_dr) | (axis_ow & ~hi_rd);
      end
   end

   // High bytes read since the set flags last rose
   assign next_seen = (all_dr || all_ow) ? (hi_seen | hi_rd) : 3'h0;

   // All-axes flags; set wins over the clear from the final read
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         all_dr  <= 1'b0;
         all_ow  <= 1'b0;
         hi_seen <= '0;
      end else begin
         if (&next_seen) begin
            hi_seen <= '0;
         end else begin
            hi_seen <= next_seen;
         end
         if (&next_axis_dr && |i_mag_done) begin
            all_dr <= 1'b1;
         end else if (&next_seen) begin
            all_dr <= 1'b0;
         end
         if (|(i_mag_done & axis_dr)) begin
            all_ow <= 1'b1;
         end else if (&next_seen) begin
            all_ow <= 1'b0;
         end
      end
   end

   // Live status image
   always_comb begin
      o_mag_status = aoms_pkg::STAT_RESET;
      o_mag_status[aoms_pkg::STAT_ALL_OW] = all_ow;
      o_mag_status[aoms_pkg::STAT_OW_LO +: 3] = axis_ow;
      o_mag_status[aoms_pkg::STAT_ALL_DR] = all_dr;
      o_mag_status[aoms_pkg::STAT_DR_LO +: 3] = axis_dr;
   end

   // Read data, one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg_rd) begin
         unique case (i_reg_addr)
            aoms_pkg::ADDR_ACC_X_HI: o_reg_rdata <= hi_byte(acc_x);
            aoms_pkg::ADDR_ACC_X_LO: o_reg_rdata <= lo_byte(acc_x);
            aoms_pkg::ADDR_ACC_Y_HI: o_reg_rdata <= hi_byte(acc_y);
            aoms_pkg::ADDR_ACC_Y_LO: o_reg_rdata <= lo_byte(acc_y);
            aoms_pkg::ADDR_ACC_Z_HI: o_reg_rdata <= hi_byte(acc_z);
            aoms_pkg::ADDR_ACC_Z_LO: o_reg_rdata <= lo_byte(acc_z);
            aoms_pkg::ADDR_X_TRIM:   o_reg_rdata <= accel_x_trim;
            aoms_pkg::ADDR_Y_TRIM:   o_reg_rdata <= accel_y_trim;
            aoms_pkg::ADDR_Z_TRIM:   o_reg_rdata <= accel_z_trim;
            aoms_pkg::ADDR_MAG_STAT: o_reg_rdata <= o_mag_status;
            default:                 o_reg_rdata <= 8'h00;
         endcase
      end
   end
endmodule

// ---- aoms_regs_properties.sv ----
/* Port assertions for the trim and magnetic status bank.
   Bound to aoms_regs; sees only its ports. */
`timescale 1ns/1ps
module aoms_regs_props (
   input wire logic       i_clk_sys,
   input wire logic       i_reset_n,
   input wire logic       i_standby,
   input wire logic [7:0] i_reg_addr,
   input wire logic       i_reg_wr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic       i_reg_rd,
   input wire logic [7:0] o_reg_rdata,
   input wire logic [2:0] i_mag_done,
   input wire logic [7:0] o_mag_status
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   // High byte reads; a done in the same cycle would win, so excluded
   wire rd_x = i_reg_rd && i_reg_addr == 8'h33 && !i_mag_done[0];
   wire rd_y = i_reg_rd && i_reg_addr == 8'h35 && !i_mag_done[1];
   wire rd_z = i_reg_rd && i_reg_addr == 8'h37 && !i_mag_done[2];
   // Trim write followed at once by a read of the same place
   sequence s_wr_x; i_reg_wr && i_standby && i_reg_addr == 8'h2f; endsequence
   sequence s_rd_x; i_reg_rd && i_reg_addr == 8'h2f; endsequence
   a_trim_readback: assert property (
      s_wr_x ##1 s_rd_x |=> o_reg_rdata == $past(i_reg_wdata, 2))
      else $error("trim readback");
   a_x_dr_set: assert property (
      i_mag_done[0] |=> o_mag_status[0])
      else $error("x new data not set");
   a_z_overwrite: assert property (
      i_mag_done[2] && o_mag_status[2]
      |=> o_mag_status[6] && o_mag_status[7])
      else $error("z overwrite");
   a_x_read_clr: assert property (
      rd_x |=> (o_mag_status & 8'h11) == 8'h00)
      else $error("x flags not cleared");
   a_y_read_clr: assert property (
      rd_y |=> (o_mag_status & 8'h22) == 8'h00)
      else $error("y flags not cleared");
   a_z_read_clr: assert property (
      rd_z |=> (o_mag_status & 8'h44) == 8'h00)
      else $error("z flags not cleared");
   a_status_read: assert property (
      i_reg_rd && i_reg_addr == 8'h32
      |=> o_reg_rdata == $past(o_mag_status))
      else $error("status read");
   a_all_dr_cause: assert property (
      $rose(o_mag_status[3]) |-> $past(i_mag_done) != 3'h0)
      else $error("set flag without sample");
endmodule
bind aoms_regs aoms_regs_props u_props (.i_clk_sys, .i_reset_n, .i_standby,
   .i_reg_addr, .i_reg_wr, .i_reg_wdata, .i_reg_rd, .o_reg_rdata,
   .i_mag_done, .o_mag_status);

// ---- aoms_host.sv ----
/* Host model on the register strobe port.
   Assumes each task is entered just after a rising edge. */
`timescale 1ns/1ps
module aoms_host (
   input  wire logic       i_clk_sys,
   output logic            o_standby,
   output logic            o_wr,
   output logic            o_rd,
   output logic      [7:0] o_addr,
   output logic      [7:0] o_wdata
);
   // Parked in standby so trim writes are legal from the start
   initial begin
      o_standby = 1'b1;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 8'h00;
      o_wdata = 8'h00;
   end
   // One strobe a cycle; the next call or mode() releases it
   task automatic op(input logic w, r, input logic [7:0] a, d);
      o_wr <= w;
      o_rd <= r;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clk_sys);
   endtask
   // Mode change doubles as an idle cycle on the strobes
   task automatic mode(input logic s);
      o_standby <= s;
      op(1'b0, 1'b0, 8'h00, 8'h00);
   endtask
endmodule

// ---- aoms_regs_tb_top.sv ----
/* Self-checking bench for the trim and magnetic status bank.
   Register traffic goes through the host model. */
`timescale 1ns/1ps
module aoms_regs_tb_top;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        av = 1'b0;
   logic [2:0]  done = 3'h0;
   logic [13:0] ax = 14'h0100;
   logic        sb, wr, rd;
   logic [7:0]  addr, wd, rdata, stat;
   logic [15:0] ex;
   logic [7:0]  tv[3] = '{8'he2, 8'h80, 8'h7f};
   logic [7:0]  left[3] = '{8'h8e, 8'h8c, 8'h00};
   int          num_errors = 0;
   int          num_checks = 0;
   always #10 clk = ~clk;
   aoms_host host (.i_clk_sys(clk), .o_standby(sb), .o_wr(wr), .o_rd(rd),
      .o_addr(addr), .o_wdata(wd));
   aoms_regs DUT (.i_clk_sys(clk), .i_reset_n(rst_n), .i_standby(sb),
      .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wd), .i_reg_rd(rd),
      .o_reg_rdata(rdata), .i_accel_valid(av), .i_accel_x(ax),
      .i_accel_y(ax), .i_accel_z(ax), .i_mag_done(done), .o_mag_status(stat));
   task automatic print_verdict;
      if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] s, e);
      num_checks++;
      if (s !== e) begin
         num_errors++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask
   // Data lands one edge after the read strobe is taken
   task automatic rd_chk(input logic [7:0] a, e);
      host.op(1'b0, 1'b1, a, 8'h00);
      host.mode(sb);
      chk("rdata", rdata, e);
   endtask
   task automatic mag(input logic [2:0] m);
      done <= m;
      @(posedge clk);
      done <= 3'h0;
      @(posedge clk);
   endtask
   task automatic st(input logic [7:0] e);
      chk("status", stat, e);
      rd_chk(8'h32, e);
   endtask
   // Watchdog: a hang counts as a failure
   initial begin
      repeat (3000) @(posedge clk);
      num_errors++;
      print_verdict;
   end
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         rd_chk(8'(8'h2f + i), 8'h00);
      end
      for (int i = 0; i < 3; i++) begin
         host.op(1'b1, 1'b0, 8'(8'h2f + i), tv[i]);
         rd_chk(8'(8'h2f + i), tv[i]);
      end
      host.op(1'b1, 1'b0, 8'h32, 8'h55);
      rd_chk(8'h32, 8'h00);
      host.mode(1'b0);
      host.op(1'b1, 1'b0, 8'h2f, 8'h55);
      rd_chk(8'h2f, 8'he2);
      av <= 1'b1;
      @(posedge clk);
      av <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 3; i++) begin
         ex = 16'((256 + 8 * int'(signed'(tv[i]))) * 4);
         rd_chk(8'(1 + 2 * i), ex[15:8]);
         rd_chk(8'(2 + 2 * i), ex[7:0]);
      end
      mag(3'h1);
      st(8'h01);
      mag(3'h1);
      st(8'h91);
      mag(3'h6);
      st(8'h9f);
      for (int i = 0; i < 3; i++) begin
         rd_chk(8'(8'h33 + 2 * i), 8'h00);
         st(left[i]);
      end
      mag(3'h4);
      mag(3'h4);
      st(8'hc4);
      print_verdict;
   end
endmodule
